// file: dv/host_core_model.sv
module host_core_model (
  input  wire logic            ref_clk,
  input  wire logic            reqReady_ff,
  input  wire logic            done_ff,
  input  wire logic            illegal_ff,
  input  wire logic [127:0]    result_ff,
  input  wire logic [63:0]     hostRdData_ff,
  output simd_pkg::simd_req_t  req,
  output logic                 reqValid,
  output simd_pkg::bank_host_t host
);
  timeunit 1ns;
  timeprecision 100ps;
  import simd_pkg::*;
  // quiet bus at time zero
  initial begin
    reqValid = 1'h0;
    req = '0;
    host = '0;
  end
  // core writes one double of the shared bank
  task automatic wr_dbl(input logic [4:0] a, input logic [63:0] d);
    @(posedge ref_clk) #1;
    host = '{1'h1, a, d};
    @(posedge ref_clk) #1;
    host = '{1'h0, a, ~d};  // released data no longer shows the written value
  endtask
  // core reads one double; data lands one edge after the address
  task automatic rd_dbl(input logic [4:0] a, output logic [63:0] d);
    @(posedge ref_clk) #1;
    host = '{1'h0, a, 64'h0};
    @(posedge ref_clk) #1;
    d = hostRdData_ff;
  endtask
  // one request: taken at the next edge, answer expected exactly two edges on
  task automatic issue(input simd_req_t r, output logic [127:0] res, output logic ill, output logic ok);
    @(posedge ref_clk) #1;
    reqValid = 1'h1;
    req = r;
    @(posedge ref_clk) #1;
    reqValid = 1'h0;
    req = ~r;  // stale fields inverted once released
    @(posedge ref_clk) #1;
    ok = (done_ff === 1'h1);
    res = result_ff;
    ill = illegal_ff;
  endtask
endmodule // host_core_model

// file: dv/packed_simd_vector_datapath_tb_top.sv
module packed_simd_vector_datapath_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import simd_pkg::*;
  typedef struct packed {simd_req_t r; logic [127:0] res; logic ill;} row_t;  // request and its answer
  logic         ref_clk, rst, clrSat, reqValid, reqReady_ff, done_ff, illegal_ff, satFlag_ff, gotIll, ok;
  logic [127:0] result_ff, got;
  logic [63:0]  hostRdData_ff, rdv;
  simd_req_t    req;
  bank_host_t   host;
  row_t         rows [26];
  int           errCount = 0;
  int           nCompared = 0;

  simd_datapath dut_u (.ref_clk, .rst, .reqValid, .req, .clrSat, .host, .reqReady_ff, .done_ff, .illegal_ff,
    .result_ff, .satFlag_ff, .hostRdData_ff);
  host_core_model hostModel_u (.ref_clk, .reqReady_ff, .done_ff, .illegal_ff, .result_ff, .hostRdData_ff,
    .req, .reqValid, .host);

  // request builder: double view, D5 = D1 op D2 unless told otherwise
  function automatic simd_req_t mk(op_t o, kind_t k, esize_t s, mod_t m = 4'h0, shape_t sh = SH_NORM,
    logic q = 1'h0, logic [4:0] a = 5'h01, logic [4:0] b = 5'h02, logic [4:0] d = 5'h05, logic sc = 1'h0);
    return '{o, k, s, sh, q, m, sc, 3'h0, 6'h00, d, a, b};
  endfunction
  task automatic cmp_vec(input logic [127:0] g, input logic [127:0] e);
    nCompared++;
    if (g !== e) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    nCompared++;
    if (g !== e) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // 10 MHz core clock
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard, far beyond the hundred or so cycles needed
  initial begin
    #300000;
    errCount++;
    conclude();
  end
  // main sequence; sources D1 = ff03, D2 = 0104
  initial begin
    rst = 1'h1;
    clrSat = 1'h0;
    rows[0]  = '{mk(OP_ADD, K_UNS, SZ8), 128'h7, 1'h0};
    rows[1]  = '{mk(OP_ADD, K_UNS, SZ8, 4'h8), 128'hff07, 1'h0};
    rows[2]  = '{mk(OP_ADD, K_UNS, SZ8, 4'h4), 128'h8003, 1'h0};
    rows[3]  = '{mk(OP_ADD, K_UNS, SZ8, 4'h5), 128'h8004, 1'h0};
    rows[4]  = '{mk(OP_CEQ, K_UNS, SZ8), 128'hffffffffffff0000, 1'h0};
    rows[5]  = '{mk(OP_MUL, K_POLY, SZ8, 4'h0, SH_NORM, 1'h0, 5'h01, 5'h01), 128'h5505, 1'h0};
    rows[6]  = '{mk(OP_CNT, K_UNS, SZ8), 128'h0802, 1'h0};
    rows[7]  = '{mk(OP_CLZ, K_UNS, SZ8), 128'h0808080808080006, 1'h0};
    rows[8]  = '{mk(OP_PADD, K_UNS, SZ8), 128'h0000000500000002, 1'h0};
    rows[9]  = '{mk(OP_MUL, K_FLT, SZ16), 128'h0, 1'h1};
    rows[10] = '{mk(OP_MUL, K_UNS, SZ32, 4'h0, SH_NORM, 1'h0, 5'h01, 5'h10, 5'h05, 1'h1), 128'h0, 1'h1};
    rows[11] = '{mk(OP_ADD, K_UNS, SZ8, 4'h0, SH_NORM, 1'h1, 5'h11), 128'h0, 1'h1};
    rows[12] = '{mk(OP_MUL, K_UNS, SZ8, 4'h0, SH_LONG, 1'h0, 5'h01, 5'h02, 5'h04), 128'h00ff000c, 1'h0};
    rows[13] = '{mk(OP_ADD, K_UNS, SZ64, 4'h0, SH_NORM, 1'h1, 5'h00, 5'h01, 5'h03),
                 128'h000000000000ff030000000000000104, 1'h0};
    rows[14] = '{mk(OP_SUB, K_SGN, SZ8, 4'hc), 128'hffff, 1'h0};
    rows[15] = '{mk(OP_CGT, K_SGN, SZ8, 4'h0, SH_NORM, 1'h0, 5'h02, 5'h01), 128'hffff, 1'h0};
    rows[16] = '{mk(OP_MUL, K_SGN, SZ16, 4'h2), 128'h8000, 1'h0};
    rows[17] = '{mk(OP_ADD, K_UNS, SZ8, 4'h8, SH_NARROW, 1'h0, 5'h00, 5'h01),
                 128'h000000ff000000ff, 1'h0};
    rows[18] = '{mk(OP_ADD, K_UNS, SZ8, 4'h0, SH_WIDE, 1'h0, 5'h00, 5'h02),
                 128'h000000000000ff030000000000010004, 1'h0};
    rows[19] = '{mk(OP_ADD, K_UNS, SZ8, 4'h0, SH_NORM, 1'h0, 5'h01, 5'h02, 5'h05, 1'h1),
                 128'h0404040404040307, 1'h0};
    rows[20] = '{mk(OP_MUL, K_FLT, SZ32), 128'h0, 1'h0};
    rows[21] = '{mk(OP_I2F, K_UNS, SZ32), 128'h477f0300, 1'h0};
    rows[22] = '{mk(OP_F2I, K_UNS, SZ32, 4'h0, SH_NORM, 1'h0, 5'h05), 128'hff03, 1'h0};
    rows[23] = '{mk(OP_CLS, K_SGN, SZ8), 128'h0707070707070705, 1'h0};
    rows[24] = '{mk(OP_AND, K_UNS, SZ8), 128'h0100, 1'h0};
    rows[25] = '{mk(OP_EOR, K_UNS, SZ8), 128'hfe07, 1'h0};
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'h0;
    hostModel_u.wr_dbl(5'h01, 64'hff03);
    hostModel_u.wr_dbl(5'h02, 64'h0104);
    foreach (rows[i]) begin
      hostModel_u.issue(rows[i].r, got, gotIll, ok);
      cmp_bit(ok, 1'h1);
      cmp_bit(gotIll, rows[i].ill);
      cmp_vec(got, rows[i].res);
    end
    $display("table of operations done");
    cmp_bit(satFlag_ff, 1'h1);
    @(posedge ref_clk) #1 clrSat = 1'h1;
    @(posedge ref_clk) #1 clrSat = 1'h0;
    cmp_bit(satFlag_ff, 1'h0);
    $display("sticky flag test done");
    hostModel_u.rd_dbl(5'h07, rdv);
    cmp_vec({64'h0, rdv}, 128'hff03);
    $display("shared bank read test done");
    @(posedge ref_clk) #1 rst = 1'h1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'h0;
    cmp_vec(result_ff, 128'h0);
    cmp_bit(reqReady_ff, 1'h1);
    hostModel_u.rd_dbl(5'h07, rdv);
    cmp_vec({64'h0, rdv}, 128'h0);
    $display("reset test done");
    conclude();
  end
endmodule // packed_simd_vector_datapath_tb_top

// file: dv/simd_datapath_chk.sv
module simd_datapath_chk (
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         reqValid,
  input wire logic         clrSat,
  input wire logic         reqReady_ff,
  input wire logic         done_ff,
  input wire logic         illegal_ff,
  input wire logic [127:0] result_ff,
  input wire logic         satFlag_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  // all checks live in the core clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_answer_two_edges: assert property (reqValid && reqReady_ff |=> !reqReady_ff ##1 (done_ff && reqReady_ff))
    else $error("answer not two edges after take");
  a_done_one_cycle: assert property (done_ff |=> !done_ff)
    else $error("done held longer than one cycle");
  a_done_has_cause: assert property ($rose(done_ff) |-> $past(reqValid && reqReady_ff, 2))
    else $error("done without a taken request");
  a_refuse_with_done: assert property (illegal_ff |-> done_ff)
    else $error("refusal flag without done");
  a_refuse_zero_result: assert property (illegal_ff |-> result_ff == 128'h0)
    else $error("refused request left a result");
  a_result_holds: assert property (!done_ff |-> $stable(result_ff))
    else $error("result moved without an answer");
  a_sat_sticky: assert property (satFlag_ff && !clrSat |=> satFlag_ff)
    else $error("saturation flag dropped by itself");
  a_sat_clears: assert property (clrSat && reqReady_ff |=> !satFlag_ff)
    else $error("saturation flag not cleared");
  a_sat_set_cause: assert property ($rose(satFlag_ff) |-> done_ff && !illegal_ff)
    else $error("saturation flag set without legal writeback");
endmodule // simd_datapath_chk

bind simd_datapath simd_datapath_chk chk_u (.ref_clk, .rst, .reqValid, .clrSat, .reqReady_ff, .done_ff,
  .illegal_ff, .result_ff, .satFlag_ff);

// file: hdl/simd_datapath.sv
module simd_datapath (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 reqValid,
  input  wire simd_pkg::simd_req_t  req,
  input  wire logic                 clrSat,
  input  wire simd_pkg::bank_host_t host,
  output logic                      reqReady_ff,
  output logic                      done_ff,
  output logic                      illegal_ff,
  output logic [127:0]              result_ff,
  output logic                      satFlag_ff,
  output logic [63:0]               hostRdData_ff
);
  import simd_pkg::*;

  st_t              state_ff;   // sequencer state
  simd_req_t        op_ff;      // request under execution
  logic             ill_ff;     // request was refused
  logic [QW-1:0]    rdA;        // first operand from bank
  logic [QW-1:0]    rdB;        // second operand from bank
  logic [QW-1:0]    res;        // assembled lane results
  logic             satAny;     // some lane saturated
  logic             take;       // request accepted this edge
  logic             wbEn;       // write result to bank
  logic signed [XW-1:0] a;      // lane operand a
  logic signed [XW-1:0] b;      // lane operand b
  logic signed [XW-1:0] r;      // lane result
  logic [XW-1:0]    rm;         // lane result masked to width
  logic [QW-1:0]    src;        // pairwise source vector
  logic [DW-1:0]    top;        // element aligned to bit 63
  logic             hit;        // clamp occurred in lane
  logic             sg;         // signed elements
  int unsigned      w;          // element width
  int unsigned      aw;         // operand a width
  int unsigned      bw;         // operand b width
  int unsigned      rw;         // result element width
  int unsigned      lanes;      // result lane count
  int unsigned      k;          // pairwise element index

  // quad view of destination, selected by form only
  function automatic logic q_dst(input simd_req_t x);
    q_dst = (x.shape == SH_NORM) ? x.quad : (x.shape != SH_NARROW);
  endfunction

  // quad view of first source
  function automatic logic q_a(input simd_req_t x);
    q_a = (x.shape == SH_NORM) ? x.quad : (x.shape != SH_LONG);
  endfunction

  // quad view of second source; scalars always come from a double
  function automatic logic q_b(input simd_req_t x);
    q_b = x.scalar ? 1'b0 : ((x.shape == SH_NORM) ? x.quad : (x.shape == SH_NARROW));
  endfunction

  // register number to first double of the bank
  function automatic logic [4:0] bank_addr(input logic [4:0] n, input logic q);
    bank_addr = q ? {n[3:0], 1'b0} : n;
  endfunction

  // refuse what the datapath cannot do
  function automatic logic is_illegal(input simd_req_t x);
    logic flt;
    logic cvt;
    flt = (x.kind == K_FLT);
    cvt = (x.op == OP_F2I) || (x.op == OP_I2F);
    is_illegal = 1'b0;
    if ((q_dst(x) && x.dst[4]) || (q_a(x) && x.srcA[4]) || (q_b(x) && x.srcB[4])) begin
      is_illegal = 1'b1;
    end
    if (flt && (x.size != SZ32 || x.op != OP_MUL || x.shape != SH_NORM || x.mods != '0)) begin
      is_illegal = 1'b1;
    end
    if (x.kind == K_POLY && (x.size > SZ16 || x.op != OP_MUL || x.shape == SH_WIDE || x.shape == SH_NARROW)) begin
      is_illegal = 1'b1;
    end
    if (cvt && (flt || x.kind == K_POLY || x.size != SZ32 || x.shape != SH_NORM)) begin
      is_illegal = 1'b1;
    end
    if ((x.op == OP_MUL || x.shape != SH_NORM) && x.size == SZ64) begin
      is_illegal = 1'b1;
    end
    if (x.op == OP_PADD && (x.shape != SH_NORM || x.scalar)) begin
      is_illegal = 1'b1;
    end
    if (x.scalar && (32'(x.lane) * (EB8 << x.size)) >= DW) begin
      is_illegal = 1'b1;
    end
    if (x.scalar && x.op == OP_MUL) begin
      if (!((x.size == SZ16 && 32'(x.srcB) < MUL16LIM) || (x.size == SZ32 && 32'(x.srcB) < MUL32LIM))) begin
        is_illegal = 1'b1;
      end
    end
  endfunction

  // pull one element out of a vector, extended to lane width
  function automatic logic signed [XW-1:0] ext(input logic [QW-1:0] v, input int unsigned sh,
                                               input int unsigned wd, input logic s);
    logic [QW-1:0] t;
    logic [XW-1:0] m;
    t = v >> sh;
    m = (XW'(1) << wd) - XW'(1);
    ext = {{(XW-DW){1'b0}}, t[DW-1:0]} & m;
    if (s && t[wd-1]) begin
      ext = ext | ~m;
    end
  endfunction

  // clamp to the range of a wd-bit element
  function automatic logic signed [XW-1:0] clampv(input logic signed [XW-1:0] v, input int unsigned wd,
                                                  input logic s, output logic h);
    logic signed [XW-1:0] mx;
    logic signed [XW-1:0] mn;
    mx = s ? $signed((XW'(1) << (wd - 1)) - XW'(1)) : $signed((XW'(1) << wd) - XW'(1));
    mn = s ? -mx - XW'(1) : '0;
    h = (v > mx) || (v < mn);
    clampv = (v > mx) ? mx : ((v < mn) ? mn : v);
  endfunction

  // carry-less product of two 16-bit polynomials
  function automatic logic [31:0] clmul(input logic [15:0] x, input logic [15:0] y);
    clmul = '0;
    for (int i = 0; i < 16; i++) begin
      if (y[i]) begin
        clmul = clmul ^ (32'(x) << i);
      end
    end
  endfunction

  // leading zeros of a top-aligned element, at most wd
  function automatic logic [6:0] lead0(input logic [DW-1:0] t, input int unsigned wd);
    logic fnd;
    fnd = 1'b0;
    lead0 = '0;
    for (int i = DW - 1; i >= 0; i--) begin
      if (t[i]) fnd = 1'b1;
      else if (!fnd) lead0 = lead0 + 7'h01;
    end
    if (32'(lead0) > wd) lead0 = 7'(wd);
  endfunction

  // set bits of a top-aligned element
  function automatic logic [6:0] pop(input logic [DW-1:0] t);
    pop = '0;
    for (int i = 0; i < DW; i++) begin
      pop = pop + 7'(t[i]);
    end
  endfunction

  // float32 multiply, round to nearest even, denormals as zero
  function automatic logic [31:0] fmul(input logic [31:0] x, input logic [31:0] y);
    logic              s;
    logic [47:0]       p;
    logic signed [10:0] e;
    logic [24:0]       m;
    logic              g;
    logic              st;
    s = x[31] ^ y[31];
    fmul = {s, 31'h0};
    if ((x[30:23] == FEMAX && x[22:0] != '0) || (y[30:23] == FEMAX && y[22:0] != '0)) begin
      fmul = FNAN;
    end else if (x[30:23] == FEMAX || y[30:23] == FEMAX) begin
      fmul = (x[30:23] == '0 || y[30:23] == '0) ? FNAN : {s, FINF};
    end else if (x[30:23] != '0 && y[30:23] != '0) begin
      p = 48'({1'b1, x[22:0]}) * 48'({1'b1, y[22:0]});
      e = $signed({3'h0, x[30:23]}) + $signed({3'h0, y[30:23]}) - FBIAS;
      if (p[47]) begin
        m = {1'b0, p[47:24]};
        g = p[23];
        st = |p[22:0];
        e = e + 11'sh001;
      end else begin
        m = {1'b0, p[46:23]};
        g = p[22];
        st = |p[21:0];
      end
      if (g && (st || m[0])) m = m + 25'h0000001;
      if (m[24]) begin
        m = m >> 1;
        e = e + 11'sh001;
      end
      if (e >= FEMAXS) fmul = {s, FINF};
      else if (e > 11'sh000) fmul = {s, e[7:0], m[FMW-1:0]};
    end
  endfunction

  // float32 to 32-bit integer or fixed point, toward zero, saturating
  function automatic logic [31:0] f2i(input logic [31:0] x, input logic s, input logic [5:0] fb);
    logic signed [10:0] e;
    logic [63:0]       mg;
    logic [31:0]       iv;
    logic [31:0]       lim;
    e = $signed({3'h0, x[30:23]}) - FBIAS + $signed({5'h00, fb});
    lim = s ? (x[31] ? S32MIN : S32MAX) : (x[31] ? 32'h00000000 : U32MAX);
    mg = 64'({1'b1, x[22:0]}) << e[4:0];
    iv = mg[FMW+31:FMW];
    if (x[30:23] == FEMAX) f2i = (x[22:0] != '0) ? 32'h00000000 : lim;
    else if (x[30:23] == '0 || e < 11'sh000) f2i = '0;
    else if (e > 11'sh01f) f2i = lim;
    else if (!s) f2i = x[31] ? 32'h00000000 : iv;
    else if (!x[31]) f2i = (iv > S32MAX) ? lim : iv;
    else f2i = (iv > S32MIN) ? lim : -iv;
  endfunction

  // 32-bit integer or fixed point to float32, round to nearest even
  function automatic logic [31:0] i2f(input logic [31:0] x, input logic s, input logic [5:0] fb);
    logic              n;
    logic [31:0]       mg;
    logic [31:0]       nm;
    logic [24:0]       m;
    logic signed [10:0] e;
    int unsigned       pm;
    n = s & x[31];
    mg = n ? -x : x;
    pm = 0;
    for (int i = 0; i < 32; i++) begin
      if (mg[i]) pm = i;
    end
    nm = mg << (31 - pm);
    m = {1'b0, nm[31:8]};
    e = 11'(pm) + FBIAS - $signed({5'h00, fb});
    if (nm[7] && ((|nm[6:0]) || m[0])) m = m + 25'h0000001;
    if (m[24]) begin
      m = m >> 1;
      e = e + 11'sh001;
    end
    i2f = (mg == '0 || e <= 11'sh000) ? 32'h00000000 : {n, e[7:0], m[FMW-1:0]};
  endfunction

  assign take = reqValid && reqReady_ff && (state_ff == ST_IDLE);
  assign wbEn = (state_ff == ST_EXEC) && !ill_ff;

  simd_reg_bank u_bank (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .rdAddrA       (bank_addr(req.srcA, q_a(req))),
    .rdAddrB       (bank_addr(req.srcB, q_b(req))),
    .rdDataA_ff    (rdA),
    .rdDataB_ff    (rdB),
    .wrEn          (wbEn),
    .wrQuad        (q_dst(op_ff)),
    .wrAddr        (bank_addr(op_ff.dst, q_dst(op_ff))),
    .wrData        (res),
    .host          (host),
    .hostRdData_ff (hostRdData_ff)
  );

  // per-lane execution over the captured operands
  always_comb begin
    res = '0;
    satAny = 1'b0;
    a = '0;
    b = '0;
    r = '0;
    rm = '0;
    src = '0;
    top = '0;
    hit = 1'b0;
    k = 0;
    sg = (op_ff.kind == K_SGN);
    w = EB8 << op_ff.size;
    aw = (op_ff.shape == SH_WIDE || op_ff.shape == SH_NARROW) ? 2 * w : w;
    bw = (op_ff.shape == SH_NARROW) ? 2 * w : w;
    rw = (op_ff.shape == SH_LONG || op_ff.shape == SH_WIDE) ? 2 * w : w;
    lanes = (q_dst(op_ff) ? QW : DW) / rw;
    for (int e = 0; e < MAXLANES; e++) begin
      if (e < lanes) begin
        if (op_ff.op == OP_PADD) begin
          src = (e < lanes / 2) ? rdA : rdB;
          k = 2 * (e % (lanes / 2));
          a = ext(src, k * aw, aw, sg);
          b = ext(src, (k + 1) * aw, aw, sg);
        end else begin
          a = ext(rdA, e * aw, aw, sg);
          b = ext(rdB, (op_ff.scalar ? 32'(op_ff.lane) : e) * bw, bw, sg);
        end
        top = a[DW-1:0] << (DW - w);
        case (op_ff.op)
          OP_ADD, OP_PADD: r = a + b;
          OP_SUB: r = a - b;
          OP_MUL: begin
            if (op_ff.kind == K_POLY) r = $signed(XW'(clmul(a[15:0], b[15:0])));
            else if (op_ff.kind == K_FLT) r = $signed(XW'(fmul(a[31:0], b[31:0])));
            else r = a * b;
          end
          OP_CEQ: r = (a == b) ? '1 : '0;
          OP_CGT: r = (a > b) ? '1 : '0;
          OP_AND: r = a & b;
          OP_EOR: r = a ^ b;
          OP_CNT: r = $signed(XW'(pop(top)));
          OP_CLZ: r = $signed(XW'(lead0(top, w)));
          OP_CLS: r = $signed(XW'(lead0(top ^ (top << 1), w - 1)));
          OP_F2I: r = $signed(XW'(f2i(a[31:0], sg, op_ff.frac)));
          OP_I2F: r = $signed(XW'(i2f(a[31:0], sg, op_ff.frac)));
          default: r = '0;
        endcase
        if (op_ff.mods.dbl) r = r <<< 1;
        if (op_ff.mods.halve) r = (r + $signed(XW'(op_ff.mods.rnd))) >>> 1;
        if (op_ff.mods.sat || op_ff.mods.dbl) begin
          r = clampv(r, rw, sg, hit);
          satAny = satAny | hit;
        end
        rm = r & ((XW'(1) << rw) - XW'(1));
        res = res | (QW'(rm[DW-1:0]) << (e * rw));
      end
    end
  end

  // sequencer: one request in flight, answer two edges after acceptance
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      reqReady_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (take) begin
            state_ff <= ST_EXEC;
            reqReady_ff <= 1'b0;
          end
        end
        ST_EXEC: begin
          state_ff <= ST_IDLE;
          reqReady_ff <= 1'b1;
        end
        default: begin
          state_ff <= ST_IDLE;
          reqReady_ff <= 1'b1;
        end
      endcase
    end
  end

  // capture the accepted request and its legality
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op_ff <= '0;
      ill_ff <= 1'b0;
    end else if (take) begin
      op_ff <= req;
      ill_ff <= is_illegal(req);
    end
  end

  // answer: result, done pulse and refusal pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
      result_ff <= '0;
    end else begin
      done_ff <= (state_ff == ST_EXEC);
      illegal_ff <= (state_ff == ST_EXEC) && ill_ff;
      if (state_ff == ST_EXEC) begin
        result_ff <= ill_ff ? '0 : res;
      end
    end
  end

  // sticky saturation flag; a new saturation beats a clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      satFlag_ff <= 1'b0;
    end else if (wbEn && satAny) begin
      satFlag_ff <= 1'b1;
    end else if (clrSat) begin
      satFlag_ff <= 1'b0;
    end
  end
endmodule // simd_datapath

// file: hdl/simd_pkg.sv
// How it works
// - float32, signed/unsigned 8-64, poly 8/16 elements
// - half floats refused by every arithmetic operation
// - poly multiply is carry-less, xor of partials
// - float results always round to nearest even
// - denormal float inputs and results become zero
// - bank seen as 16 quads or 32 doubles
// - each request's form alone picks the view
// - normal shape keeps operand size and type
// - long shape: doubles in, double-width quad out
// - wide shape: quad plus promoted double, quad out
// - narrow shape: quads in, half-width double out
// - scalar lane of a double applied to all
// - scalar multiply: 16-bit doubles 0-7, 32-bit 0-15
// - lanes equal register width over element width
// - convert float32 to/from 32-bit integer, fixed point
// - saturation clamps lanes, sets sticky flag
// - halving shifts lane result right, truncating
// - doubling multiplies by two then saturates
// - rounding adds half an lsb before truncation
// - compares give all-ones or all-zeros lanes
// - pairwise add sums adjacent source elements
// - count set bits, leading zeros, leading signs
// - one physical bank shared with scalar float unit
package simd_pkg;
  localparam int unsigned QW       = 128;    // quad register width
  localparam int unsigned DW       = 64;     // double register width
  localparam int unsigned NDBL     = 32;     // doubles in the bank
  localparam int unsigned XW       = 68;     // internal lane arithmetic width
  localparam int unsigned MAXLANES = 16;     // most lanes in one result
  localparam int unsigned EB8      = 8;      // smallest element width
  localparam int unsigned MUL16LIM = 8;      // doubles reachable by 16-bit scalars
  localparam int unsigned MUL32LIM = 16;     // doubles reachable by 32-bit scalars
  localparam int unsigned FMW      = 23;     // float32 fraction bits
  localparam logic [7:0]  FEMAX    = 8'hff;  // float32 all-ones exponent
  localparam logic signed [10:0] FBIAS = 11'sh07f;  // float32 exponent bias
  localparam logic signed [10:0] FEMAXS = 11'sh0ff; // overflow exponent
  localparam logic [31:0] FNAN     = 32'h7fc00000;  // default quiet nan
  localparam logic [30:0] FINF     = 31'h7f800000;  // infinity magnitude
  localparam logic [31:0] S32MAX   = 32'h7fffffff;  // signed 32-bit max
  localparam logic [31:0] S32MIN   = 32'h80000000;  // signed 32-bit min
  localparam logic [31:0] U32MAX   = 32'hffffffff;  // unsigned 32-bit max

  typedef enum logic [1:0] {K_UNS = 2'b00, K_SGN = 2'b01, K_POLY = 2'b10, K_FLT = 2'b11} kind_t;
  typedef enum logic [1:0] {SZ8 = 2'b00, SZ16 = 2'b01, SZ32 = 2'b10, SZ64 = 2'b11} esize_t;
  typedef enum logic [1:0] {SH_NORM = 2'b00, SH_LONG = 2'b01, SH_WIDE = 2'b10, SH_NARROW = 2'b11} shape_t;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MUL = 4'h2, OP_PADD = 4'h3, OP_CEQ = 4'h4, OP_CGT = 4'h5,
    OP_AND = 4'h6, OP_EOR = 4'h7, OP_CNT = 4'h8, OP_CLZ = 4'h9, OP_CLS = 4'ha, OP_F2I = 4'hb,
    OP_I2F = 4'hc
  } op_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_EXEC = 1'b1} st_t;

  typedef struct packed {
    logic sat;    // clamp to element range
    logic halve;  // shift result right by one
    logic dbl;    // double then saturate
    logic rnd;    // round before halving
  } mod_t;

  typedef struct packed {
    op_t        op;      // operation
    kind_t      kind;    // element kind
    esize_t     size;    // element size (narrow side for shaped ops)
    shape_t     shape;   // operand shape
    logic       quad;    // normal shape: quad view
    mod_t       mods;    // modifiers
    logic       scalar;  // second operand is a lane of a double
    logic [2:0] lane;    // scalar lane index
    logic [5:0] frac;    // fixed-point fraction bits for conversion
    logic [4:0] dst;     // destination register number
    logic [4:0] srcA;    // first source register number
    logic [4:0] srcB;    // second source register number
  } simd_req_t;

  typedef struct packed {
    logic        wr;    // write one double
    logic [4:0]  addr;  // double register number
    logic [63:0] data;  // write data
  } bank_host_t;
endpackage

// file: hdl/simd_reg_bank.sv
module simd_reg_bank
  import simd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  rdAddrA,
  input  wire logic [4:0]  rdAddrB,
  output logic [127:0]     rdDataA_ff,
  output logic [127:0]     rdDataB_ff,
  input  wire logic        wrEn,
  input  wire logic        wrQuad,
  input  wire logic [4:0]  wrAddr,
  input  wire logic [127:0] wrData,
  input  wire simd_pkg::bank_host_t host,
  output logic [63:0]      hostRdData_ff
);
  logic [DW-1:0] mem [0:NDBL-1];  // the one physical bank of doubles

  // registered reads; an even address yields the whole quad pair
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdDataA_ff    <= '0;
      rdDataB_ff    <= '0;
      hostRdData_ff <= '0;
    end else begin
      rdDataA_ff    <= {mem[rdAddrA | 5'h01], mem[rdAddrA]};
      rdDataB_ff    <= {mem[rdAddrB | 5'h01], mem[rdAddrB]};
      hostRdData_ff <= mem[host.addr];
    end
  end

  // host/float unit writes first so a datapath write to the same double wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NDBL; i++) begin
        mem[i] <= '0;
      end
    end else begin
      if (host.wr) begin
        mem[host.addr] <= host.data;
      end
      if (wrEn) begin
        mem[wrAddr] <= wrData[DW-1:0];
        if (wrQuad) begin
          mem[wrAddr | 5'h01] <= wrData[QW-1:DW];
        end
      end
    end
  end
endmodule // simd_reg_bank
